/* File: hw/iepr_arbiter.sv */
// picks the winning request by level, then by fixed polling order
// assumes requests already gated by enables; slot 0 is polled first
`timescale 1ns/100ps

module iepr_arbiter #(
    parameter int NUM_SLOTS = 15
) (
    input  wire logic [NUM_SLOTS-1:0]   i_req,
    input  wire logic [2*NUM_SLOTS-1:0] i_level,
    output logic                        o_valid,
    output logic [3:0]                  o_slot,
    output iepr_pkg::iepr_level_t       o_level
);

    ////////////////////////////////////////////////////////////////////////////
    // scan from lowest-priority slot upward so slot 0 wins ties
    always_comb
    begin
        o_valid = 1'b0;
        o_slot  = 4'h0;
        o_level = 2'b00;
        for (int s = NUM_SLOTS - 1; s >= 0; s--)
        begin
            // strictly higher level wins, equal level goes to the lower slot
            if (i_req[s] && (!o_valid || i_level[2*s +: 2] >= o_level))
            begin
                o_valid = 1'b1;
                o_slot  = 4'(s);
                o_level = i_level[2*s +: 2];
            end
        end
    end

endmodule

/* File: hw/iepr_pkg.sv */
// types shared by the interrupt enable and priority block
// assumes nothing beyond a SystemVerilog compiler
package iepr_pkg;

    // number of polling slots, slot 0 served first
    localparam int NUM_SLOTS = 15;

    // two-bit priority level, 0 lowest and 3 highest
    typedef logic [1:0] iepr_level_t;

    // service tracker states
    typedef enum logic [1:0] {
        IEPR_IDLE,
        IEPR_ACK,
        IEPR_DONE
    } iepr_svc_t;

endpackage

/* File: hw/iepr_regs.svh */
// register offsets, field positions and reset values of the interrupt enable and priority block
// assumes the core decodes an 8-bit special-function address space
`ifndef IEPR_REGS_SVH
`define IEPR_REGS_SVH

// special-function addresses
`define IEPR_ADDR_EN0      8'hA8
`define IEPR_ADDR_EN1      8'hB1
`define IEPR_ADDR_PL1      8'hB2
`define IEPR_ADDR_PH1      8'hB3
`define IEPR_ADDR_PH0      8'hB7
`define IEPR_ADDR_PL0      8'hB8

// field positions
`define IEPR_BIT_GLOBAL    7
`define IEPR_BIT_AUDIO     6
`define IEPR_BIT_SERIAL    4
`define IEPR_BIT_TIMER1    3
`define IEPR_BIT_EXT1      2
`define IEPR_BIT_TIMER0    1
`define IEPR_BIT_EXT0      0
`define IEPR_BIT_USB       6
`define IEPR_BIT_KEYPAD    4
`define IEPR_BIT_CONV      3
`define IEPR_BIT_SPI       2
`define IEPR_BIT_TWOWIRE   1
`define IEPR_BIT_CARD      0

// writable-bit masks; cleared bits read as zero
`define IEPR_MASK_EN0      8'hDF
`define IEPR_MASK_EN1      8'h5F
`define IEPR_MASK_P0       8'h5F
`define IEPR_MASK_P1       8'h5F

// reset value of every register
`define IEPR_RESET_VAL     8'h00

`endif

/* File: hw/iepr_service.sv */
// keeps the stack of levels currently in service
// assumes the core pulses acknowledge on vectoring and return on the end of a routine
`timescale 1ns/100ps

module iepr_service (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_ack,
    input  wire iepr_pkg::iepr_level_t i_ack_level,
    input  wire logic                  i_return,
    output logic [3:0]                 o_active
);

    // one bit per level in service; nesting can only rise so a bit set is enough
    logic [3:0] active_q;
    logic [3:0] active_d;
    logic [3:0] top_mask;

    ////////////////////////////////////////////////////////////////////////////
    // return clears the highest active level only
    assign top_mask = active_q[3] ? 4'h8 :
                      active_q[2] ? 4'h4 :
                      active_q[1] ? 4'h2 :
                      active_q[0] ? 4'h1 : 4'h0;

    // an acknowledge in the same cycle as a return still sets its level
    always_comb
    begin
        active_d = active_q;
        if (i_return)
        begin
            active_d = active_d & ~top_mask;
        end
        if (i_ack)
        begin
            active_d[i_ack_level] = 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            active_q <= 4'h0;
        else
            active_q <= active_d;
    end

    assign o_active = active_q;

endmodule

/* File: hw/iepr_top.sv */
// interrupt enable and priority registers with the request arbiter
// assumes a core-side special-function read/write port and synchronous request flags
//
// Summary of operation
// - global enable clear masks every source
// - first enable register bit-to-source map
// - second enable register bit-to-source map
// - first enable bit 5 reads zero
// - second enable/priority bits 7,5 read zero
// - first priority bit 7 read undefined
// - high priority bit beside enable bit
// - low priority bit beside enable bit
// - reset clears all registers
// - level is high bit over low bit
// - higher level preempts; ties use polling order
`timescale 1ns/100ps
`include "iepr_regs.svh"

module iepr_top #(
    parameter int NUM_SLOTS = iepr_pkg::NUM_SLOTS
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic [7:0]            i_sfr_addr,
    input  wire logic [7:0]            i_sfr_wdata,
    input  wire logic                  i_sfr_wr,
    input  wire logic                  i_sfr_rd,
    output logic [7:0]                 o_sfr_rdata,
    output logic                       o_sfr_hit,
    input  wire logic [NUM_SLOTS-1:0]  i_src_flag,
    input  wire logic                  i_irq_ack,
    input  wire logic                  i_irq_return,
    output logic                       o_irq_req,
    output logic [3:0]                 o_irq_slot,
    output iepr_pkg::iepr_level_t      o_irq_level,
    output logic [3:0]                 o_in_service
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] en0_q;          // interrupt_enable_0
    logic [7:0] en1_q;          // interrupt_enable_1
    logic [7:0] ph0_q;          // priority_high_0
    logic [7:0] pl0_q;          // priority_low_0
    logic [7:0] ph1_q;          // priority_high_1
    logic [7:0] pl1_q;          // priority_low_1
    logic [7:0] rdata_q;        // registered read data

    // address decode wires
    logic       sel_en0;
    logic       sel_en1;
    logic       sel_ph0;
    logic       sel_pl0;
    logic       sel_ph1;
    logic       sel_pl1;
    logic       sel_any;
    logic [7:0] rdata_d;

    // shared register address compare for the six select wires;
    // a miss on all six leaves the read mux at zero and drops the write
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
        addr_hit = (a == r);
    endfunction

    assign sel_en0 = addr_hit(i_sfr_addr, `IEPR_ADDR_EN0);
    assign sel_en1 = addr_hit(i_sfr_addr, `IEPR_ADDR_EN1);
    assign sel_ph0 = addr_hit(i_sfr_addr, `IEPR_ADDR_PH0);
    assign sel_pl0 = addr_hit(i_sfr_addr, `IEPR_ADDR_PL0);
    assign sel_ph1 = addr_hit(i_sfr_addr, `IEPR_ADDR_PH1);
    assign sel_pl1 = addr_hit(i_sfr_addr, `IEPR_ADDR_PL1);
    assign sel_any = sel_en0 | sel_en1 | sel_ph0 | sel_pl0 | sel_ph1 | sel_pl1;

    // hit flags the core that this block owns the address, combinational
    assign o_sfr_hit = sel_any;

    ////////////////////////////////////////////////////////////////////////////
    // register writes; reserved positions are never stored, which also
    // keeps reserved slots out of arbitration even if software breaks
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            en0_q <= `IEPR_RESET_VAL;
            en1_q <= `IEPR_RESET_VAL;
            ph0_q <= `IEPR_RESET_VAL;
            pl0_q <= `IEPR_RESET_VAL;
            ph1_q <= `IEPR_RESET_VAL;
            pl1_q <= `IEPR_RESET_VAL;
        end
        else if (i_sfr_wr)
        begin
            if (sel_en0) en0_q <= i_sfr_wdata & `IEPR_MASK_EN0;
            if (sel_en1) en1_q <= i_sfr_wdata & `IEPR_MASK_EN1;
            if (sel_ph0) ph0_q <= i_sfr_wdata & `IEPR_MASK_P0;
            if (sel_pl0) pl0_q <= i_sfr_wdata & `IEPR_MASK_P0;
            if (sel_ph1) ph1_q <= i_sfr_wdata & `IEPR_MASK_P1;
            if (sel_pl1) pl1_q <= i_sfr_wdata & `IEPR_MASK_P1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; reserved bits come back as zero, which the undefined
    // bit 7 of the first priority pair is also allowed to return
    assign rdata_d = sel_en0 ? en0_q :
                     sel_en1 ? en1_q :
                     sel_ph0 ? ph0_q :
                     sel_pl0 ? pl0_q :
                     sel_ph1 ? ph1_q :
                     sel_pl1 ? pl1_q :
                     8'h00;

    // read data is registered on the edge that samples the read strobe and holds until the next read
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            rdata_q <= 8'h00;
        else if (i_sfr_rd)
            rdata_q <= rdata_d;
    end

    assign o_sfr_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // per-slot enable and level, in polling order
    logic [NUM_SLOTS-1:0]   slot_en;
    logic [2*NUM_SLOTS-1:0] slot_lvl;

    // builds a level from the high and low register bits
    function automatic iepr_pkg::iepr_level_t mk_level(input logic hi, input logic lo);
        mk_level = {hi, lo};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // named enable fields; reserved positions have no name and no storage
    logic global_irq_enable;      // master gate over every source
    logic audio_irq_enable;       // audio interface
    logic serial_irq_enable;      // serial port
    logic timer1_irq_enable;      // timer 1 overflow
    logic ext1_irq_enable;        // external input 1
    logic timer0_irq_enable;      // timer 0 overflow
    logic ext0_irq_enable;        // external input 0
    logic usb_irq_enable;         // usb interface
    logic keypad_irq_enable;      // keyboard port
    logic converter_irq_enable;   // analogue converter
    logic spi_irq_enable;         // spi controller
    logic two_wire_irq_enable;    // two-wire controller
    logic card_irq_enable;        // card interface

    // high halves of the levels, at the enable bit position of each source
    logic audio_prio_msb;
    logic serial_prio_msb;
    logic timer1_prio_msb;
    logic ext1_prio_msb;
    logic timer0_prio_msb;
    logic ext0_prio_msb;
    logic usb_prio_msb;
    logic keypad_prio_msb;
    logic converter_prio_msb;
    logic spi_prio_msb;
    logic two_wire_prio_msb;
    logic card_prio_msb;

    // low halves of the levels, same positions as the high halves
    logic audio_prio_lsb;
    logic serial_prio_lsb;
    logic timer1_prio_lsb;
    logic ext1_prio_lsb;
    logic timer0_prio_lsb;
    logic ext0_prio_lsb;
    logic usb_prio_lsb;
    logic keypad_prio_lsb;
    logic converter_prio_lsb;
    logic spi_prio_lsb;
    logic two_wire_prio_lsb;
    logic card_prio_lsb;

    // the decoder pair at bit 5 of the first priority registers is left out:
    // no source polls from that slot, so storing it would only let software
    // park a level where nothing can ever request
    ////////////////////////////////////////////////////////////////////////////
    // field extraction; plain wires so the slot map reads like the layout
    assign global_irq_enable    = en0_q[`IEPR_BIT_GLOBAL];
    assign audio_irq_enable     = en0_q[`IEPR_BIT_AUDIO];
    assign serial_irq_enable    = en0_q[`IEPR_BIT_SERIAL];
    assign timer1_irq_enable    = en0_q[`IEPR_BIT_TIMER1];
    assign ext1_irq_enable      = en0_q[`IEPR_BIT_EXT1];
    assign timer0_irq_enable    = en0_q[`IEPR_BIT_TIMER0];
    assign ext0_irq_enable      = en0_q[`IEPR_BIT_EXT0];
    // second enable register
    assign usb_irq_enable       = en1_q[`IEPR_BIT_USB];
    assign keypad_irq_enable    = en1_q[`IEPR_BIT_KEYPAD];
    assign converter_irq_enable = en1_q[`IEPR_BIT_CONV];
    assign spi_irq_enable       = en1_q[`IEPR_BIT_SPI];
    assign two_wire_irq_enable  = en1_q[`IEPR_BIT_TWOWIRE];
    assign card_irq_enable      = en1_q[`IEPR_BIT_CARD];

    // high bits come from the high register of the same half
    assign audio_prio_msb       = ph0_q[`IEPR_BIT_AUDIO];
    assign serial_prio_msb      = ph0_q[`IEPR_BIT_SERIAL];
    assign timer1_prio_msb      = ph0_q[`IEPR_BIT_TIMER1];
    assign ext1_prio_msb        = ph0_q[`IEPR_BIT_EXT1];
    assign timer0_prio_msb      = ph0_q[`IEPR_BIT_TIMER0];
    assign ext0_prio_msb        = ph0_q[`IEPR_BIT_EXT0];
    // second high register
    assign usb_prio_msb         = ph1_q[`IEPR_BIT_USB];
    assign keypad_prio_msb      = ph1_q[`IEPR_BIT_KEYPAD];
    assign converter_prio_msb   = ph1_q[`IEPR_BIT_CONV];
    assign spi_prio_msb         = ph1_q[`IEPR_BIT_SPI];
    assign two_wire_prio_msb    = ph1_q[`IEPR_BIT_TWOWIRE];
    assign card_prio_msb        = ph1_q[`IEPR_BIT_CARD];

    // low bits come from the low register of the same half
    assign audio_prio_lsb       = pl0_q[`IEPR_BIT_AUDIO];
    assign serial_prio_lsb      = pl0_q[`IEPR_BIT_SERIAL];
    assign timer1_prio_lsb      = pl0_q[`IEPR_BIT_TIMER1];
    assign ext1_prio_lsb        = pl0_q[`IEPR_BIT_EXT1];
    assign timer0_prio_lsb      = pl0_q[`IEPR_BIT_TIMER0];
    assign ext0_prio_lsb        = pl0_q[`IEPR_BIT_EXT0];
    // second low register
    assign usb_prio_lsb         = pl1_q[`IEPR_BIT_USB];
    assign keypad_prio_lsb      = pl1_q[`IEPR_BIT_KEYPAD];
    assign converter_prio_lsb   = pl1_q[`IEPR_BIT_CONV];
    assign spi_prio_lsb         = pl1_q[`IEPR_BIT_SPI];
    assign two_wire_prio_lsb    = pl1_q[`IEPR_BIT_TWOWIRE];
    assign card_prio_lsb        = pl1_q[`IEPR_BIT_CARD];

    // slot order: ext0, timer0, ext1, timer1, serial, reserved, audio,
    // card, two-wire, spi, converter, keypad, reserved, usb, reserved
    // unused slots 5, 12 and 14 keep the zero defaults
    always_comb
    begin
        slot_en  = '0;
        slot_lvl = '0;
        slot_en[0]  = ext0_irq_enable;
        slot_en[1]  = timer0_irq_enable;
        slot_en[2]  = ext1_irq_enable;
        slot_en[3]  = timer1_irq_enable;
        slot_en[4]  = serial_irq_enable;
        slot_en[6]  = audio_irq_enable;
        slot_en[7]  = card_irq_enable;
        slot_en[8]  = two_wire_irq_enable;
        slot_en[9]  = spi_irq_enable;
        slot_en[10] = converter_irq_enable;
        slot_en[11] = keypad_irq_enable;
        slot_en[13] = usb_irq_enable;

        // two-bit level of each slot, high bit over low bit
        slot_lvl[1:0]   = mk_level(ext0_prio_msb, ext0_prio_lsb);
        slot_lvl[3:2]   = mk_level(timer0_prio_msb, timer0_prio_lsb);
        slot_lvl[5:4]   = mk_level(ext1_prio_msb, ext1_prio_lsb);
        slot_lvl[7:6]   = mk_level(timer1_prio_msb, timer1_prio_lsb);
        slot_lvl[9:8]   = mk_level(serial_prio_msb, serial_prio_lsb);
        slot_lvl[13:12] = mk_level(audio_prio_msb, audio_prio_lsb);
        slot_lvl[15:14] = mk_level(card_prio_msb, card_prio_lsb);
        slot_lvl[17:16] = mk_level(two_wire_prio_msb, two_wire_prio_lsb);
        slot_lvl[19:18] = mk_level(spi_prio_msb, spi_prio_lsb);
        slot_lvl[21:20] = mk_level(converter_prio_msb, converter_prio_lsb);
        slot_lvl[23:22] = mk_level(keypad_prio_msb, keypad_prio_lsb);
        slot_lvl[27:26] = mk_level(usb_prio_msb, usb_prio_lsb);
    end

    ////////////////////////////////////////////////////////////////////////////
    // gating: flag and own enable and global enable
    logic [NUM_SLOTS-1:0]  gated_req;
    logic                  win_valid;
    logic [3:0]            win_slot;
    iepr_pkg::iepr_level_t win_level;
    logic [3:0]            active;
    logic                  beats_active;

    // the master gate sits in front of the arbiter so one clear silences all
    assign gated_req = global_irq_enable ? (i_src_flag & slot_en) : '0;

    iepr_arbiter #(
        .NUM_SLOTS (NUM_SLOTS)
    ) u_arb (
        .i_req     (gated_req),
        .i_level   (slot_lvl),
        .o_valid   (win_valid),
        .o_slot    (win_slot),
        .o_level   (win_level)
    );

    iepr_service u_svc (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_ack       (i_irq_ack & o_irq_req),
        .i_ack_level (win_level),
        .i_return    (i_irq_return),
        .o_active    (active)
    );

    // only a level strictly above every level in service may preempt
    assign beats_active = ((active >> win_level) == 4'h0);

    assign o_irq_req    = win_valid & beats_active;
    assign o_irq_slot   = win_slot;
    assign o_irq_level  = win_level;
    assign o_in_service = active;

endmodule

/* File: testbench/iepr_chk.sv */
// port checker for the interrupt enable and priority block
// assumes it is bound onto iepr_top and sees only its ports
`timescale 1ns/100ps
module iepr_chk #(
    parameter int NUM_SLOTS = 15
) (
    input wire logic                  i_clk,
    input wire logic                  i_nrst,
    input wire logic [7:0]            i_sfr_addr,
    input wire logic [7:0]            i_sfr_wdata,
    input wire logic                  i_sfr_wr,
    input wire logic                  i_sfr_rd,
    input wire logic [7:0]            o_sfr_rdata,
    input wire logic [NUM_SLOTS-1:0]  i_src_flag,
    input wire logic                  i_irq_ack,
    input wire logic                  i_irq_return,
    input wire logic                  o_irq_req,
    input wire logic [3:0]            o_in_service,
    input wire logic [3:0]            o_irq_slot,
    input wire iepr_pkg::iepr_level_t o_irq_level
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    ////////////////
    logic glob_q;  // shadow of the global enable, kept from the write strobes
    // shadow follows the same edge as the register itself
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            glob_q <= 1'b0;
        else if (i_sfr_wr && i_sfr_addr == 8'hA8)
            glob_q <= i_sfr_wdata[7];
    end
    ////////////////
    a_reset_clears: assert property ($rose(i_nrst) |-> o_sfr_rdata == 8'h00 && o_in_service == 4'h0 && !o_irq_req)
        else $error("state not clear after reset");
    a_en0_res_zero: assert property (i_sfr_rd && i_sfr_addr == 8'hA8 |=> !o_sfr_rdata[5])
        else $error("enable 0 bit 5 read nonzero");
    a_set1_res_zero: assert property (i_sfr_rd && i_sfr_addr inside {8'hB1, 8'hB2, 8'hB3} |=>
        !o_sfr_rdata[7] && !o_sfr_rdata[5]) else $error("set 1 reserved bit read nonzero");
    a_slot5_res_zero: assert property (i_sfr_rd && i_sfr_addr inside {8'hB7, 8'hB8} |=> !o_sfr_rdata[5])
        else $error("unused slot bit read nonzero");
    a_global_masks: assert property (!glob_q |-> !o_irq_req)
        else $error("request with global enable clear");
    a_req_flagged: assert property (o_irq_req |-> i_src_flag[o_irq_slot])
        else $error("request without a flag");
    a_req_above_svc: assert property (o_irq_req |-> (o_in_service >> o_irq_level) == 4'h0)
        else $error("request not above service level");
    a_ack_marks_lvl: assert property (i_irq_ack && o_irq_req && !i_irq_return |=> o_in_service[$past(o_irq_level)])
        else $error("acknowledged level not in service");
    a_ret_pops_one: assert property (i_irq_return && !i_irq_ack && o_in_service != 4'h0 |=>
        $countones(o_in_service) + 1 == $countones($past(o_in_service))) else $error("return did not pop one");
endmodule
bind iepr_top iepr_chk #(.NUM_SLOTS(NUM_SLOTS)) iepr_chk_i (.i_clk, .i_nrst, .i_sfr_addr, .i_sfr_wdata,
    .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata, .i_src_flag, .i_irq_ack, .i_irq_return, .o_irq_req, .o_in_service,
    .o_irq_slot, .o_irq_level);

/* File: testbench/iepr_core_model.sv */
// core-side model: vectors on a request and later ends the routine
// assumes the bench seeds the random generator once
`timescale 1ns/100ps
module iepr_core_model (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_req,
    input  wire logic i_slow,
    output logic      o_ack,
    output logic      o_ret
);
    int wait_n = 0;  // cycles left before the next vectoring
    int depth  = 0;  // routines now running; no return without one
    initial
    begin
        o_ack = 1'b0;
        o_ret = 1'b0;
    end
    // pulses move just after the edge so the block samples them cleanly
    always @(posedge i_clk)
    begin
        logic r;
        r = i_req;
        #1;
        o_ack = i_nrst && r && wait_n == 0;
        o_ret = i_nrst && depth > 0 && $urandom_range(3) == 0;
        depth = i_nrst ? depth + o_ack - o_ret : 0;
        if (o_ack)
            wait_n = i_slow ? 3 : 0;
        else if (wait_n > 0)
            wait_n--;
    end
endmodule

/* File: testbench/tb.sv */
// self-checking bench: register access and request arbitration
// assumes the core model and the bound checker are compiled first
`timescale 1ns/100ps
module tb;
    logic                  i_clk  = 1'b0;
    logic                  i_nrst = 1'b0;
    logic [7:0]            addr   = 8'h00;
    logic [7:0]            wdata  = 8'h00;
    logic                  wr     = 1'b0;
    logic                  rd     = 1'b0;
    logic [14:0]           flag   = 15'h0000;
    logic                  slow   = 1'b0;
    logic [7:0]            rdata;
    logic                  hit;
    logic                  req;
    logic                  ack;
    logic                  ret;
    logic [3:0]            slot;
    logic [3:0]            svc;
    iepr_pkg::iepr_level_t lvl;
    int                    n_errors   = 0;
    int                    num_checks = 0;
    int                    cyc        = 0;
    int                    m [6];     // model registers
    int                    ms = 0;    // model in-service bits
    localparam int ad [6] = '{8'hA8, 8'hB1, 8'hB2, 8'hB3, 8'hB7, 8'hB8};
    localparam int mk [6] = '{8'hDF, 8'h5F, 8'h5F, 8'h5F, 8'h5F, 8'h5F};  // stored bits
    ////////////////
    iepr_top iepr_top_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_src_flag(flag),
        .i_irq_ack(ack), .i_irq_return(ret), .o_irq_req(req), .o_irq_slot(slot), .o_irq_level(lvl),
        .o_in_service(svc));
    iepr_core_model iepr_core_model_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_slow(slow),
        .o_ack(ack), .o_ret(ret));
    always #25 i_clk = ~i_clk;
    ////////////////
    function automatic int idx(logic [7:0] a);
        foreach (ad[k])
            if (a == ad[k])
                return k;
        return -1;
    endfunction
    // winner as 64 + slot*4 + level, or below 64 when nothing may request
    function automatic int arb();
        int best = 0;
        int e, h, lo, b, lv;
        for (int s = 0; s < 15; s++)
        begin
            b = (s < 7) ? s : s - 7;
            e = (s < 7) ? m[0] : m[1];
            h = (s < 7) ? m[4] : m[3];
            lo = (s < 7) ? m[5] : m[2];
            lv = h[b] * 2 + lo[b];
            if (flag[s] && m[0][7] && e[b] && lv > $clog2(ms + 1) - 1 && (best < 64 || lv > best % 4))
                best = 64 + s * 4 + lv;
        end
        return best;
    endfunction
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge i_clk);
        #1;
        wr = w;
        rd = ~w;
        addr = a;
        wdata = d;
        @(posedge i_clk);
        #1;
        wr = 1'b0;
        rd = 1'b0;
    endtask
    // read, then let one more edge pass; the data holds until the next read
    task automatic rdc(logic [7:0] a, logic [7:0] e);
        bus(1'b0, a, 8'h00);
        @(posedge i_clk);
        chk("read_data", e, rdata);
        chk("sfr_hit", 8'(idx(a) >= 0), {7'h00, hit});
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////
    // model compared with the outputs at every edge out of reset, then stepped
    always @(posedge i_clk)
    begin
        int x;
        x = arb();
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            finish_test();
        end
        if (!i_nrst)
        begin
            ms = 0;
            m = '{0, 0, 0, 0, 0, 0};
        end
        else
        begin
            chk("irq_req", 8'(x / 64), {7'h00, req});
            if (x >= 64)
                chk("irq_pick", 8'(x % 64), {2'h0, slot, lvl});
            chk("in_service", 8'(ms), {4'h0, svc});
            if (ret && ms != 0)
                ms = ms & ~(1 << ($clog2(ms + 1) - 1));
            if (ack && x >= 64)
                ms = ms | (1 << (x % 4));
            if (wr && idx(addr) >= 0)
                m[idx(addr)] = wdata & mk[idx(addr)];
        end
    end
    ////////////////
    initial
    begin
        int k;
        void'($urandom(32'h79ad));
        repeat (4) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        foreach (ad[j])
            rdc(ad[j], 8'h00);
        rdc(8'hA9, 8'h00);
        foreach (ad[j])
            bus(1'b1, ad[j], 8'hFF);
        bus(1'b1, 8'hA9, 8'hFF);
        foreach (ad[j])
            rdc(ad[j], mk[j]);
        rdc(8'hA9, 8'h00);
        for (int i = 0; i < 150; i++)
        begin
            k = $urandom_range(5);
            @(posedge i_clk);
            #1;
            flag = 15'($urandom);
            slow = 1'($urandom);
            bus(1'b1, ad[k], 8'(($urandom | (k == 0 && i % 4 != 0 ? 32'h0080 : 0)) & mk[k]));
            if (i % 5 == 0)
                rdc(ad[k], 8'(m[k]));
        end
        @(posedge i_clk);
        #1 i_nrst = 1'b0;
        repeat (4) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        foreach (ad[j])
            rdc(ad[j], 8'h00);
        finish_test();
    end
endmodule
